//--- debug_port_mode_switch.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Any reset sets the debug pins to digital, pulled-up, alternate use.
// - Clearing alternate-function bits hands the debug pins to general I/O.
// - Pin setting writes land only when unlocked and the commit bit is set.
// - Ten alternating switches from serial, in external reset, erase flash.
// - Flash erase finishes before nonvolatile configuration is restored.
// - The three-fold TAP preamble from reset selects serial-wire mode.
// - Each pattern switch opens with at least 50 high line cycles.
// - Pattern E79E, LSB first, selects serial-wire mode.
// - 50 highs after it put an active serial-wire engine in line reset.
// - Pattern E73C, LSB first, selects boundary-scan mode.
// - Five high cycles afterwards leave the TAP in Test-Logic-Reset.
// - Debug traffic resumes only once alternate function is set again.
// - No bus register reaches the TAP or its chains; the alternate-function register only gates its steps.
// - Boundary-scan works straight after reset with no software setup.
// - Power-on reset forces the TAP into Test-Logic-Reset.
// - Five high mode-select cycles reset the TAP state machine.
module debug_port_mode_switch
	import debug_port_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_tck,
	input  wire logic        i_tms,
	input  wire logic        i_ext_rst_n,
	input  wire logic        i_flash_erase_done,
	input  wire logic        i_nv_restore_done,
	input  wire logic        i_axi_awvalid,
	output logic             o_axi_awready,
	input  wire logic [7:0]  i_axi_awaddr,
	input  wire logic        i_axi_wvalid,
	output logic             o_axi_wready,
	input  wire logic [31:0] i_axi_wdata,
	input  wire logic [3:0]  i_axi_wstrb,
	output logic             o_axi_bvalid,
	input  wire logic        i_axi_bready,
	output logic [1:0]       o_axi_bresp,
	input  wire logic        i_axi_arvalid,
	output logic             o_axi_arready,
	input  wire logic [7:0]  i_axi_araddr,
	output logic             o_axi_rvalid,
	input  wire logic        i_axi_rready,
	output logic [31:0]      o_axi_rdata,
	output logic [1:0]       o_axi_rresp,
	output logic [3:0]       o_pin_alt_func,
	output logic [3:0]       o_pin_pullup,
	output logic [3:0]       o_pin_digital_en,
	output logic             o_mode_swd,
	output logic             o_tap_reset,
	output logic             o_swd_line_reset,
	output logic             o_flash_erase_req,
	output logic             o_nv_restore_req
);

	logic          tck_meta_r;
	logic          tck_sync_r;
	logic          tck_prev_r;
	logic          tms_meta_r;
	logic          tms_sync_r;
	logic          ext_meta_r;
	logic          ext_sync_r;
	logic          tck_rise;
	logic          ext_held;
	logic          dbg_active;
	logic          link_step;

	logic [3:0]    alt_func_r;
	logic [3:0]    pullup_r;
	logic [3:0]    dig_en_r;
	logic [3:0]    commit_r;
	logic          locked_r;

	logic          awready_r;
	logic          wready_r;
	logic          bvalid_r;
	logic [1:0]    bresp_r;
	logic [7:0]    awaddr_r;
	logic [31:0]   wdata_r;
	logic [3:0]    wstrb_r;
	logic          arready_r;
	logic          rvalid_r;
	logic [31:0]   rdata_r;
	logic [1:0]    rresp_r;
	logic          do_write;
	logic          lane0;
	logic          pin_wr_ok;
	logic [31:0]   status_word;
	logic [31:0]   rdata_nxt;
	logic [1:0]    rresp_nxt;

	logic [15:0]   shift_r;
	logic [15:0]   shift_nxt;
	logic [5:0]    run_cnt_r;
	logic          armed_r;
	logic [4:0]    pat_cnt_r;
	logic [4:0]    pat_cnt_nxt;
	logic          swd_match;
	logic          jtag_match;
	logic          run_done;

	mode_type      mode_r;
	logic          line_reset_r;
	tap_state_type tap_state;
	tap_state_type tap_prev_r;
	logic          tap_step_d_r;
	logic [3:0]    prm_idx_r;
	logic          prm_hit;
	logic          prm_done;

	logic [3:0]    sw_cnt_r;
	logic          expect_swd_r;
	recover_type   rec_r;
	logic          sw_good;
	logic [3:0]    sw_cnt_nxt;

	// Link pins pass two flops before use
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			tck_meta_r <= 1'b1;
			tck_sync_r <= 1'b1;
			tck_prev_r <= 1'b1;
			tms_meta_r <= 1'b1;
			tms_sync_r <= 1'b1;
			ext_meta_r <= 1'b1;
			ext_sync_r <= 1'b1;
		end
		else
		begin
			tck_meta_r <= i_tck;
			tck_sync_r <= tck_meta_r;
			tck_prev_r <= tck_sync_r;
			tms_meta_r <= i_tms;
			tms_sync_r <= tms_meta_r;
			ext_meta_r <= i_ext_rst_n;
			ext_sync_r <= ext_meta_r;
		end
	end

	assign tck_rise   = tck_sync_r & ~tck_prev_r;
	assign ext_held   = ~ext_sync_r;
	assign dbg_active = &alt_func_r;
	assign link_step  = tck_rise & dbg_active;

	// Register bus: write side
	assign do_write  = ~awready_r & ~wready_r & ~bvalid_r;
	assign lane0     = wstrb_r[0];
	assign pin_wr_ok = do_write & lane0 & ~locked_r;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
		end
		else
		begin
			if (i_axi_awvalid && awready_r)
			begin
				awready_r <= 1'b0;
				awaddr_r  <= i_axi_awaddr;
			end
			if (i_axi_wvalid && wready_r)
			begin
				wready_r <= 1'b0;
				wdata_r  <= i_axi_wdata;
				wstrb_r  <= i_axi_wstrb;
			end
			if (do_write)
			begin
				bvalid_r <= 1'b1;
				unique case (awaddr_r)
					OFS_ALT_FUNC, OFS_PULLUP, OFS_DIG_EN,
					OFS_LOCK, OFS_COMMIT, OFS_STATUS:
						bresp_r <= RESP_OKAY;
					default:
						bresp_r <= RESP_SLVERR;
				endcase
			end
			if (bvalid_r && i_axi_bready)
			begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Lock and commit gate every pin setting write
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			locked_r <= 1'b1;
			commit_r <= COMMIT_DEFAULT;
		end
		else if (do_write && awaddr_r == OFS_LOCK)
			locked_r <= !(wstrb_r == 4'hF && wdata_r == UNLOCK_KEY);
		else if (pin_wr_ok && awaddr_r == OFS_COMMIT)
			commit_r <= wdata_r[PIN_COUNT-1:0];
	end

	generate
		for (genvar i = 0; i < PIN_COUNT; i++)
		begin : g_pin
			always_ff @(posedge i_clock)
			begin
				if (!i_rst_n || ext_held)
				begin
					alt_func_r[i] <= PIN_DEFAULT[i];
					pullup_r[i]   <= PIN_DEFAULT[i];
					dig_en_r[i]   <= PIN_DEFAULT[i];
				end
				else if (pin_wr_ok && commit_r[i])
				begin
					if (awaddr_r == OFS_ALT_FUNC)
						alt_func_r[i] <= wdata_r[i];
					if (awaddr_r == OFS_PULLUP)
						pullup_r[i] <= wdata_r[i];
					if (awaddr_r == OFS_DIG_EN)
						dig_en_r[i] <= wdata_r[i];
				end
			end
		end
	endgenerate

	// Register bus: read side; of the TAP only the Test-Logic-Reset status bit is mapped
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[STAT_MODE_SWD]   = (mode_r == MODE_SWD);
		status_word[STAT_DBG_ACTIVE] = dbg_active;
		status_word[STAT_TAP_RESET]  = (tap_state == TAP_RESET);
		status_word[STAT_EXT_RESET]  = ext_held;
		status_word[STAT_SW_CNT_HI:STAT_SW_CNT_LO] = sw_cnt_r;
		status_word[STAT_REC_BUSY]   = (rec_r == REC_ERASE) ||
			(rec_r == REC_RESTORE);
		status_word[STAT_REC_DONE]   = (rec_r == REC_DONE);
		rdata_nxt = 32'h00000000;
		rresp_nxt = RESP_OKAY;
		unique case (i_axi_araddr)
			OFS_ALT_FUNC: rdata_nxt[PIN_COUNT-1:0] = alt_func_r;
			OFS_PULLUP:   rdata_nxt[PIN_COUNT-1:0] = pullup_r;
			OFS_DIG_EN:   rdata_nxt[PIN_COUNT-1:0] = dig_en_r;
			OFS_LOCK:     rdata_nxt[0] = locked_r;
			OFS_COMMIT:   rdata_nxt[PIN_COUNT-1:0] = commit_r;
			OFS_STATUS:   rdata_nxt = status_word;
			default:      rresp_nxt = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= RESP_OKAY;
		end
		else if (i_axi_arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
		else if (rvalid_r && i_axi_rready)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// Switch pattern detector on the line
	always_comb
	begin
		shift_nxt   = {tms_sync_r, shift_r[15:1]};
		pat_cnt_nxt = pat_cnt_r;
		if (armed_r && (pat_cnt_r != 5'h00 || !tms_sync_r))
			pat_cnt_nxt = pat_cnt_r + 5'h01;
	end

	assign swd_match  = link_step && pat_cnt_nxt == SWITCH_PAT_LEN &&
		shift_nxt == PAT_TO_SWD;
	assign jtag_match = link_step && pat_cnt_nxt == SWITCH_PAT_LEN &&
		shift_nxt == PAT_TO_JTAG;
	assign run_done   = link_step && tms_sync_r &&
		run_cnt_r == SWITCH_RUN_MIN - 6'h01;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			shift_r   <= 16'h0000;
			run_cnt_r <= 6'h00;
			armed_r   <= 1'b0;
			pat_cnt_r <= 5'h00;
		end
		else if (link_step)
		begin
			shift_r <= shift_nxt;
			if (!tms_sync_r)
				run_cnt_r <= 6'h00;
			else if (run_cnt_r != SWITCH_RUN_MIN)
				run_cnt_r <= run_cnt_r + 6'h01;
			if (run_done)
			begin
				armed_r   <= 1'b1;
				pat_cnt_r <= 5'h00;
			end
			else if (pat_cnt_nxt == SWITCH_PAT_LEN)
			begin
				armed_r   <= 1'b0;
				pat_cnt_r <= 5'h00;
			end
			else
				pat_cnt_r <= pat_cnt_nxt;
		end
	end

	// TAP preamble follower
	assign prm_hit  = tap_state == PREAMBLE_SEQ[prm_idx_r] &&
		(prm_idx_r != 4'h0 || tap_prev_r == TAP_RESET);
	assign prm_done = tap_step_d_r && prm_hit && prm_idx_r == PREAMBLE_LAST;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			tap_step_d_r <= 1'b0;
			tap_prev_r   <= TAP_RESET;
			prm_idx_r    <= 4'h0;
		end
		else
		begin
			tap_step_d_r <= link_step && mode_r == MODE_JTAG;
			if (tap_step_d_r)
			begin
				tap_prev_r <= tap_state;
				if (!prm_hit || prm_idx_r == PREAMBLE_LAST)
					prm_idx_r <= 4'h0;
				else
					prm_idx_r <= prm_idx_r + 4'h1;
			end
		end
	end

	// Mode select and line reset
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			mode_r       <= MODE_JTAG;
			line_reset_r <= 1'b0;
		end
		else
		begin
			line_reset_r <= run_done && mode_r == MODE_SWD;
			if (swd_match || prm_done)
				mode_r <= MODE_SWD;
			else if (jtag_match)
				mode_r <= MODE_JTAG;
		end
	end

	tap_state_tracker u_tap
	(
		.i_clock       (i_clock),
		.i_rst_n       (i_rst_n),
		.i_step        (link_step && mode_r == MODE_JTAG),
		.i_tms         (tms_sync_r),
		.i_force_reset (mode_r == MODE_SWD),
		.o_state       (tap_state)
	);

	// Recovery switch counter
	assign sw_good    = (swd_match && expect_swd_r) ||
		(jtag_match && !expect_swd_r);
	assign sw_cnt_nxt = sw_good ? sw_cnt_r + 4'h1 :
		(swd_match ? 4'h1 : 4'h0);

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || !ext_held)
		begin
			sw_cnt_r     <= 4'h0;
			expect_swd_r <= 1'b1;
		end
		else if ((swd_match || jtag_match) && sw_cnt_r != RECOVER_SWITCHES)
		begin
			sw_cnt_r     <= sw_cnt_nxt;
			expect_swd_r <= !swd_match;
		end
	end

	// Erase, then restore nonvolatile settings
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			rec_r <= REC_IDLE;
		else
		begin
			unique case (rec_r)
				REC_IDLE:
					if (ext_held && sw_cnt_r == RECOVER_SWITCHES)
						rec_r <= REC_ERASE;
				REC_ERASE:
					if (i_flash_erase_done)
						rec_r <= REC_RESTORE;
				REC_RESTORE:
					if (i_nv_restore_done)
						rec_r <= REC_DONE;
				REC_DONE:
					rec_r <= REC_DONE;
			endcase
		end
	end

	// Output flops
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_mode_swd        <= 1'b0;
			o_tap_reset       <= 1'b1;
			o_flash_erase_req <= 1'b0;
			o_nv_restore_req  <= 1'b0;
		end
		else
		begin
			o_mode_swd        <= mode_r == MODE_SWD;
			o_tap_reset       <= tap_state == TAP_RESET;
			o_flash_erase_req <= rec_r == REC_ERASE;
			o_nv_restore_req  <= rec_r == REC_RESTORE;
		end
	end

	assign o_axi_awready    = awready_r;
	assign o_axi_wready     = wready_r;
	assign o_axi_bvalid     = bvalid_r;
	assign o_axi_bresp      = bresp_r;
	assign o_axi_arready    = arready_r;
	assign o_axi_rvalid     = rvalid_r;
	assign o_axi_rdata      = rdata_r;
	assign o_axi_rresp      = rresp_r;
	assign o_pin_alt_func   = alt_func_r;
	assign o_pin_pullup     = pullup_r;
	assign o_pin_digital_en = dig_en_r;
	assign o_swd_line_reset = line_reset_r;

endmodule

//--- debug_port_mode_switch_assertions.sv
`timescale 1ns/1ps
module debug_port_mode_switch_checker
	import debug_port_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic       i_ext_rst_n,
	input  wire logic       i_flash_erase_done,
	input  wire logic       o_axi_bvalid,
	input  wire logic [3:0] o_pin_alt_func,
	input  wire logic [3:0] o_pin_pullup,
	input  wire logic [3:0] o_pin_digital_en,
	input  wire logic       o_mode_swd,
	input  wire logic       o_tap_reset,
	input  wire logic       o_swd_line_reset,
	input  wire logic       o_flash_erase_req,
	input  wire logic       o_nv_restore_req
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	AST_POR_PINS: assert property ($rose(i_rst_n) |->
		(o_pin_alt_func & o_pin_pullup & o_pin_digital_en) == 4'hF)
		else $error("pins not in debug use after reset");
	AST_POR_TAP: assert property ($rose(i_rst_n) |->
		o_tap_reset && !o_mode_swd)
		else $error("tap not in reset after power-on");
	AST_EXT_PINS: assert property (!i_ext_rst_n [*5] |->
		(o_pin_alt_func & o_pin_pullup & o_pin_digital_en) == 4'hF)
		else $error("pins not forced under external reset");
	AST_PIN_WRITE: assert property ($changed(o_pin_alt_func) &&
		o_pin_alt_func != 4'hF |-> $rose(o_axi_bvalid))
		else $error("alt function changed without a write");
	AST_ERASE_HOLD: assert property (o_flash_erase_req &&
		!i_flash_erase_done |=> o_flash_erase_req)
		else $error("erase request dropped early");
	AST_ERASE_FIRST: assert property (o_nv_restore_req |->
		!o_flash_erase_req)
		else $error("restore overlaps erase");
	AST_RESTORE_AFTER: assert property ($rose(o_nv_restore_req) |->
		$past(o_flash_erase_req))
		else $error("restore without erase");
	AST_LINE_PULSE: assert property (o_swd_line_reset |->
		o_mode_swd ##1 !o_swd_line_reset)
		else $error("line reset not a pulse in serial mode");
	AST_SWD_TAP: assert property (o_mode_swd [*3] |-> o_tap_reset)
		else $error("tap active in serial mode");
	AST_MODE_ALT: assert property ($changed(o_mode_swd) |->
		$past(o_pin_alt_func, 2) == 4'hF)
		else $error("mode changed while pins in general use");
	cover property ($rose(o_mode_swd));
	cover property (o_swd_line_reset);
	cover property ($rose(o_flash_erase_req));
	cover property ($rose(o_nv_restore_req));
endmodule

bind debug_port_mode_switch debug_port_mode_switch_checker u_chk (.i_clock,
	.i_rst_n, .i_ext_rst_n, .i_flash_erase_done, .o_axi_bvalid,
	.o_pin_alt_func, .o_pin_pullup, .o_pin_digital_en, .o_mode_swd,
	.o_tap_reset, .o_swd_line_reset, .o_flash_erase_req, .o_nv_restore_req);

//--- debug_port_mode_switch_tb_top.sv
`timescale 1ns/1ps
module debug_port_mode_switch_tb_top;
	import debug_port_pkg::*;
	localparam logic [31:0] FULL = 32'hFFFFFFFF;
	logic        i_clock = 0, i_rst_n = 0, i_ext_rst_n = 1;
	logic        i_flash_erase_done = 0, i_nv_restore_done = 0;
	logic        i_axi_awvalid = 0, i_axi_wvalid = 0, i_axi_bready = 0;
	logic        i_axi_arvalid = 0, i_axi_rready = 0;
	logic [7:0]  i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
	logic [31:0] i_axi_wdata = 32'h0;
	logic [3:0]  i_axi_wstrb = 4'hF;
	wire         i_tck, i_tms;
	logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
	logic        o_axi_rvalid, o_mode_swd, o_tap_reset, o_swd_line_reset;
	logic        o_flash_erase_req, o_nv_restore_req;
	logic [1:0]  o_axi_bresp, o_axi_rresp;
	logic [31:0] o_axi_rdata;
	logic [3:0]  o_pin_alt_func, o_pin_pullup, o_pin_digital_en, c, v;
	int          err_total = 0, checks = 0, cyc = 0, pulses = 0, p0, n;
	int          seed = 17903;
	logic [33:0] exp_q[$], msk_q[$];

	always #2 i_clock = ~i_clock;
	debug_probe_model u_probe (.o_tck(i_tck), .o_tms(i_tms));
	debug_port_mode_switch u_dut (.*);

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [33:0] ex,
		input logic [33:0] got);
		checks++;
		if (got !== ex)
		begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] rs);
		int k;
		logic dn;
		exp_q.push_back({rs, 32'h0});
		msk_q.push_back({2'h3, 32'h0});
		@(posedge i_clock);
		i_axi_awvalid <= 1;
		i_axi_awaddr <= a;
		i_axi_wvalid <= 1;
		i_axi_wdata <= d;
		i_axi_bready <= 1;
		k = 0;
		dn = 0;
		while (!dn && k < 100)
		begin
			@(posedge i_clock);
			k++;
			if (i_axi_awvalid && o_axi_awready === 1'b1) i_axi_awvalid <= 0;
			if (i_axi_wvalid && o_axi_wready === 1'b1) i_axi_wvalid <= 0;
			dn = (o_axi_bvalid === 1'b1);
		end
		i_axi_bready <= 0;
		if (!dn) err_total++;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] rs,
		input logic [31:0] ex, input logic [31:0] m);
		int k;
		logic dn;
		exp_q.push_back({rs, ex});
		msk_q.push_back({2'h3, m});
		@(posedge i_clock);
		i_axi_arvalid <= 1;
		i_axi_araddr <= a;
		i_axi_rready <= 1;
		k = 0;
		dn = 0;
		while (!dn && k < 100)
		begin
			@(posedge i_clock);
			k++;
			if (i_axi_arvalid && o_axi_arready === 1'b1) i_axi_arvalid <= 0;
			dn = (o_axi_rvalid === 1'b1);
		end
		i_axi_rready <= 0;
		if (!dn) err_total++;
	endtask
	task automatic st(input logic [31:0] ex);
		rd(OFS_STATUS, RESP_OKAY, ex, 32'hF);
	endtask

	always @(posedge i_clock)
		if (o_axi_rvalid === 1'b1 && i_axi_rready ||
			o_axi_bvalid === 1'b1 && i_axi_bready)
		begin
			check("bus", exp_q[0] & msk_q[0], (i_axi_rready ?
				{o_axi_rresp, o_axi_rdata} : {o_axi_bresp, 32'h0}) & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	always @(posedge i_clock)
		if (o_swd_line_reset === 1'b1) pulses++;
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			err_total++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1;
		rd(OFS_ALT_FUNC, RESP_OKAY, 32'hF, FULL);
		rd(OFS_PULLUP, RESP_OKAY, 32'hF, FULL);
		rd(OFS_DIG_EN, RESP_OKAY, 32'hF, FULL);
		rd(OFS_LOCK, RESP_OKAY, 32'h1, FULL);
		rd(OFS_COMMIT, RESP_OKAY, 32'h0, FULL);
		st(32'h6);
		check("tap_reset", 1, o_tap_reset);
		check("mode_swd", 0, o_mode_swd);
		check("pin_alt_func", 4'hF, o_pin_alt_func);
		rd(8'h1C, RESP_SLVERR, 32'h0, FULL);
		$display("test 1 done");
		u_probe.tms_bit(1'b0);
		st(32'h2);
		check("tap_reset", 0, o_tap_reset);
		u_probe.highs(5);
		st(32'h6);
		$display("test 2 done");
		p0 = pulses;
		u_probe.switch_seq(PAT_TO_SWD, 50);
		st(32'h7);
		check("mode_swd", 1, o_mode_swd);
		check("line_reset", 1, pulses - p0);
		p0 = pulses;
		u_probe.tms_bit(1'b0);
		u_probe.highs(50);
		check("line_reset", 1, pulses - p0);
		u_probe.tms_bit(1'b0);
		u_probe.highs(10);
		u_probe.pattern(PAT_TO_JTAG);
		st(32'h7);
		u_probe.switch_seq(PAT_TO_JTAG, 5);
		st(32'h6);
		$display("test 3 done");
		u_probe.pattern(PAT_TO_SWD);
		st(32'h7);
		check("tap_reset", 1, o_tap_reset);
		u_probe.switch_seq(PAT_TO_JTAG, 5);
		st(32'h6);
		$display("test 4 done");
		wr(OFS_ALT_FUNC, 32'h0, RESP_OKAY);
		rd(OFS_ALT_FUNC, RESP_OKAY, 32'hF, FULL);
		wr(OFS_LOCK, UNLOCK_KEY, RESP_OKAY);
		rd(OFS_LOCK, RESP_OKAY, 32'h0, FULL);
		c = 4'($random(seed));
		v = 4'($random(seed));
		wr(OFS_COMMIT, {28'h0, c}, RESP_OKAY);
		wr(OFS_PULLUP, {28'h0, v}, RESP_OKAY);
		rd(OFS_PULLUP, RESP_OKAY, {28'h0, ~c | v}, FULL);
		check("pin_pullup", {30'h0, ~c | v}, o_pin_pullup);
		wr(OFS_COMMIT, 32'hF, RESP_OKAY);
		wr(OFS_ALT_FUNC, 32'h0, RESP_OKAY);
		rd(OFS_ALT_FUNC, RESP_OKAY, 32'h0, FULL);
		st(32'h4);
		u_probe.switch_seq(PAT_TO_SWD, 50);
		st(32'h4);
		wr(OFS_ALT_FUNC, 32'hF, RESP_OKAY);
		u_probe.switch_seq(PAT_TO_SWD, 50);
		st(32'h7);
		u_probe.switch_seq(PAT_TO_JTAG, 5);
		wr(OFS_DIG_EN, 32'h0, RESP_OKAY);
		rd(OFS_DIG_EN, RESP_OKAY, 32'h0, FULL);
		i_axi_wstrb <= 4'($random(seed)) & 4'hE;
		wr(OFS_DIG_EN, 32'hF, RESP_OKAY);
		i_axi_wstrb <= 4'hF;
		rd(OFS_DIG_EN, RESP_OKAY, 32'h0, FULL);
		check("pin_digital_en", 0, o_pin_digital_en);
		wr(OFS_STATUS, FULL, RESP_OKAY);
		wr(OFS_LOCK, 32'h0, RESP_OKAY);
		rd(OFS_LOCK, RESP_OKAY, 32'h1, FULL);
		wr(OFS_ALT_FUNC, 32'h0, RESP_OKAY);
		rd(OFS_ALT_FUNC, RESP_OKAY, 32'hF, FULL);
		wr(8'h18, 32'h0, RESP_SLVERR);
		$display("test 5 done");
		@(posedge i_clock);
		i_ext_rst_n <= 0;
		repeat (6) @(posedge i_clock);
		rd(OFS_DIG_EN, RESP_OKAY, 32'hF, FULL);
		rd(OFS_STATUS, RESP_OKAY, 32'h8, 32'h8);
		$display("test 6 done");
		u_probe.switch_seq(PAT_TO_SWD, 0);
		u_probe.switch_seq(PAT_TO_SWD, 0);
		rd(OFS_STATUS, RESP_OKAY, 32'h10, 32'hF0);
		for (int i = 0; i < 10; i++)
			u_probe.switch_seq(i % 2 ? PAT_TO_JTAG : PAT_TO_SWD, 0);
		n = 0;
		while (o_flash_erase_req !== 1'b1 && n < 100)
		begin
			@(posedge i_clock);
			n++;
		end
		repeat (10) @(posedge i_clock);
		check("erase_req", 1, o_flash_erase_req);
		check("restore_req", 0, o_nv_restore_req);
		i_flash_erase_done <= 1;
		n = 0;
		while (o_nv_restore_req !== 1'b1 && n < 100)
		begin
			@(posedge i_clock);
			n++;
		end
		check("restore_req", 1, o_nv_restore_req);
		check("erase_req", 0, o_flash_erase_req);
		i_flash_erase_done <= 0;
		i_nv_restore_done <= 1;
		repeat (5) @(posedge i_clock);
		i_nv_restore_done <= 0;
		rd(OFS_STATUS, RESP_OKAY, 32'h200, 32'h300);
		i_ext_rst_n <= 1;
		repeat (20) @(posedge i_clock);
		$display("test 7 done");
		print_verdict();
	end
endmodule

//--- debug_port_pkg.sv
package debug_port_pkg;

	typedef enum logic [3:0]
	{
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} tap_state_type;

	typedef enum logic
	{
		MODE_JTAG,
		MODE_SWD
	} mode_type;

	typedef enum logic [1:0]
	{
		REC_IDLE,
		REC_ERASE,
		REC_RESTORE,
		REC_DONE
	} recover_type;

	localparam int          PIN_COUNT        = 4;
	localparam logic [3:0]  PIN_DEFAULT      = 4'hF;
	localparam logic [3:0]  COMMIT_DEFAULT   = 4'h0;
	localparam logic [5:0]  SWITCH_RUN_MIN   = 6'h32;
	localparam logic [4:0]  SWITCH_PAT_LEN   = 5'h10;
	localparam logic [15:0] PAT_TO_SWD       = 16'hE79E;
	localparam logic [15:0] PAT_TO_JTAG      = 16'hE73C;
	localparam logic [3:0]  RECOVER_SWITCHES = 4'hA;
	localparam logic [3:0]  PREAMBLE_LAST    = 4'hF;

	localparam tap_state_type PREAMBLE_SEQ [16] = '{
		TAP_IDLE, TAP_SEL_DR, TAP_SEL_IR, TAP_RESET,
		TAP_RESET, TAP_IDLE, TAP_IDLE, TAP_SEL_DR,
		TAP_SEL_IR, TAP_RESET, TAP_RESET, TAP_IDLE,
		TAP_IDLE, TAP_SEL_DR, TAP_SEL_IR, TAP_RESET
	};

	// Value is arbitrary
	localparam logic [31:0] UNLOCK_KEY       = 32'h4B1D5EED;

	localparam logic [7:0]  OFS_ALT_FUNC     = 8'h00;
	localparam logic [7:0]  OFS_PULLUP       = 8'h04;
	localparam logic [7:0]  OFS_DIG_EN       = 8'h08;
	localparam logic [7:0]  OFS_LOCK         = 8'h0C;
	localparam logic [7:0]  OFS_COMMIT       = 8'h10;
	localparam logic [7:0]  OFS_STATUS       = 8'h14;

	localparam int          STAT_MODE_SWD    = 0;
	localparam int          STAT_DBG_ACTIVE  = 1;
	localparam int          STAT_TAP_RESET   = 2;
	localparam int          STAT_EXT_RESET   = 3;
	localparam int          STAT_SW_CNT_LO   = 4;
	localparam int          STAT_SW_CNT_HI   = 7;
	localparam int          STAT_REC_BUSY    = 8;
	localparam int          STAT_REC_DONE    = 9;

	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

//--- debug_probe_model.sv
`timescale 1ns/1ps
module debug_probe_model
(
	output logic o_tck,
	output logic o_tms
);
	// Clock rests low between frames; line idles high on its pull-up
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
	end
	// Line changes on the falling clock edge
	task automatic tms_bit(input logic b);
		o_tms <= b;
		#62.5 o_tck = 1'b1;
		#62.5 o_tck = 1'b0;
	endtask
	task automatic highs(input int n);
		repeat (n) tms_bit(1'b1);
	endtask
	task automatic pattern(input logic [15:0] p);
		for (int i = 0; i < 16; i++)
			tms_bit(p[i]);
	endtask
	task automatic switch_seq(input logic [15:0] p, input int trail);
		highs(50);
		pattern(p);
		highs(trail);
	endtask
endmodule

//--- tap_state_tracker.sv
`timescale 1ns/1ps
module tap_state_tracker
	import debug_port_pkg::*;
(
	input  wire logic          i_clock,
	input  wire logic          i_rst_n,
	input  wire logic          i_step,
	input  wire logic          i_tms,
	input  wire logic          i_force_reset,
	output tap_state_type      o_state
);

	tap_state_type state_r;
	tap_state_type state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			TAP_RESET:    state_nxt = i_tms ? TAP_RESET    : TAP_IDLE;
			TAP_IDLE:     state_nxt = i_tms ? TAP_SEL_DR   : TAP_IDLE;
			TAP_SEL_DR:   state_nxt = i_tms ? TAP_SEL_IR   : TAP_CAP_DR;
			TAP_CAP_DR:   state_nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: state_nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: state_nxt = i_tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
			TAP_PAUSE_DR: state_nxt = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: state_nxt = i_tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
			TAP_UPD_DR:   state_nxt = i_tms ? TAP_SEL_DR   : TAP_IDLE;
			TAP_SEL_IR:   state_nxt = i_tms ? TAP_RESET    : TAP_CAP_IR;
			TAP_CAP_IR:   state_nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: state_nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: state_nxt = i_tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
			TAP_PAUSE_IR: state_nxt = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: state_nxt = i_tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
			TAP_UPD_IR:   state_nxt = i_tms ? TAP_SEL_DR   : TAP_IDLE;
		endcase
	end

	// Five high steps from any state land in reset
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			state_r <= TAP_RESET;
		else if (i_force_reset)
			state_r <= TAP_RESET;
		else if (i_step)
			state_r <= state_nxt;
	end

	assign o_state = state_r;

endmodule
